/* core/port_cd_gpio.sv */
/*
  Two 8-bit ports: first port with direction, high drive and frontplane handover; second port
  with data latch and peripheral pin takeover. APB slave on clk.
  Assumes pins come from outside the clock domain; peripheral outputs are on clk.
*/
// Register access over APB was chosen for this implementation.
//
// Function
// - Direction 1 enables buffer, 0 is Hi-Z
// - Reset clears all first-port direction bits
// - Data read: latch if output, pin if input
// - Data write always updates output latch
// - Eight high-drive bits, effective only as output
// - High-drive bit 1 selects high sink
// - Second-port latches survive reset
// - Second-port GPIO follows its direction register
// - Keypad enable takes over pins 7 to 4
// - Two-wire enable makes pins 7,6 open-drain
// - Timer two external clock owns pin 5
// - Timer one external clock owns pin 4
// - SPI enable takes pins 3 to 0
// - Calibration takes pins 3 and 0
// - First-port data latches survive reset
// - Frontplane enables hand first-port nibbles over
`timescale 1ns/10ps
`include "port_cd_regs.svh"

module port_cd_gpio
  import port_cd_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk, // Bus clock
  input wire logic rst_n, // Synchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [7:0] first_pin_in, // First-port pin levels
  output logic [7:0] first_pin_out, // First-port pin drive
  output logic [7:0] first_pin_oe, // First-port output enable
  output logic [7:0] first_high_drive, // High sink enable per pin
  input wire logic [7:0] frontplane_out, // Display frontplane levels
  output logic [7:0] frontplane_sel, // Pins owned by frontplane driver
  input wire logic [7:0] second_pin_in, // Second-port pin levels
  output logic [7:0] second_pin_out, // Second-port pin drive
  output logic [7:0] second_pin_oe, // Second-port output enable
  output logic [3:0] keypad_wake_input, // Keypad inputs from pins 7..4
  input wire logic sda_drive_low, // Two-wire data pulls low
  input wire logic scl_drive_low, // Two-wire clock pulls low
  output logic sda_in, // Two-wire data level
  output logic scl_in, // Two-wire clock level
  output logic timer_two_ext_clock, // Timer two external clock
  output logic timer_one_ext_clock, // Timer one external clock
  input wire pin_drive_t spi_drive, // SPI drive on pins 3..0
  output logic [3:0] spi_in, // SPI pin levels 3..0
  input wire logic calibration_out, // Calibration output to pin 3
  output logic calibration_in // Calibration input from pin 0
);

  logic [7:0] first_data_r;
  logic [7:0] second_data_r;
  logic [7:0] first_dir_r;
  logic [7:0] second_dir_r;
  logic [7:0] high_drive_r;
  periph_ctrl_t ctrl_r;
  wire logic [2*WIDTH-1:0] pins_raw;
  wire logic [2*WIDTH-1:0] sync_lvl;
  wire logic [7:0] s1_r;
  wire logic [7:0] s2_r;
  logic [7:0] first_out_nxt, first_oe_nxt, second_out_nxt, second_oe_nxt;
  logic [7:0] fp_sel_nxt;
  logic [31:0] rd_nxt;
  logic wr_en, mapped;

  assign wr_en = psel && penable && pwrite && pready;

  // Pins are asynchronous: three flops per bit, and the filtered level moves only once
  // the second and third flops agree, so one unsettled sample never reaches software.
  assign pins_raw = {second_pin_in, first_pin_in};

  for (genvar i = 0; i < 2 * WIDTH; i++) begin : g_sync
    logic meta_r;
    logic mid_r;
    logic last_r;
    logic level_r;

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        meta_r <= 1'b0;
        mid_r <= 1'b0;
        last_r <= 1'b0;
      end else begin
        meta_r <= pins_raw[i];
        mid_r <= meta_r;
        last_r <= mid_r;
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        level_r <= 1'b0;
      end else if (mid_r == last_r) begin
        level_r <= last_r;
      end
    end

    assign sync_lvl[i] = level_r;
  end

  assign s1_r = sync_lvl[WIDTH-1:0];
  assign s2_r = sync_lvl[2*WIDTH-1:WIDTH];

  // Data latches have no reset.
  always_ff @(posedge clk) begin
    if (wr_en && paddr == `FIRST_DATA_OFS) begin
      first_data_r <= pwdata[7:0];
    end
    if (wr_en && paddr == `SECOND_DATA_OFS) begin
      second_data_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_dir_r <= `DIR_RESET;
    end else if (wr_en && paddr == `FIRST_DIR_OFS) begin
      first_dir_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      second_dir_r <= `DIR_RESET;
    end else if (wr_en && paddr == `SECOND_DIR_OFS) begin
      second_dir_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      high_drive_r <= `HIGH_DRIVE_RESET;
    end else if (wr_en && paddr == `FIRST_HIGH_DRIVE_OFS) begin
      high_drive_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= periph_ctrl_t'(15'(`PERIPH_CTRL_RESET));
    end else if (wr_en && paddr == `PERIPH_CTRL_OFS) begin
      ctrl_r <= periph_ctrl_t'(pwdata[14:0]);
    end
  end

  // Pin muxing; later assignments take priority where peripherals overlap.
  always_comb begin
    fp_sel_nxt = {{4{ctrl_r.upper_fp}}, {4{ctrl_r.lower_fp}}};
    first_oe_nxt = first_dir_r | fp_sel_nxt;
    first_out_nxt = (first_data_r & ~fp_sel_nxt) | (frontplane_out & fp_sel_nxt);
    second_oe_nxt = second_dir_r;
    second_out_nxt = second_data_r;
    for (int i = 4; i < 8; i++) begin
      if (ctrl_r.keypad_en[i-4]) begin
        second_oe_nxt[i] = 1'b0;
      end
    end
    if (ctrl_r.t1_ps == `PS_EXT_CLOCK) begin
      second_oe_nxt[4] = 1'b0;
    end
    if (ctrl_r.t2_ps == `PS_EXT_CLOCK) begin
      second_oe_nxt[5] = 1'b0;
    end
    if (ctrl_r.two_wire_en) begin
      second_out_nxt[7:6] = 2'b00;
      second_oe_nxt[7:6] = {sda_drive_low, scl_drive_low};
    end
    if (ctrl_r.spi_en) begin
      second_out_nxt[3:0] = spi_drive.dout[3:0];
      second_oe_nxt[3:0] = spi_drive.oe[3:0];
    end
    if (ctrl_r.cal_en) begin
      second_out_nxt[3] = calibration_out;
      second_oe_nxt[3] = 1'b1;
      second_oe_nxt[0] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_pin_out <= 8'h00;
    end else begin
      first_pin_out <= first_out_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_pin_oe <= 8'h00;
    end else begin
      first_pin_oe <= first_oe_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_high_drive <= 8'h00;
    end else begin
      first_high_drive <= high_drive_r & first_dir_r & ~fp_sel_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frontplane_sel <= 8'h00;
    end else begin
      frontplane_sel <= fp_sel_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      second_pin_out <= 8'h00;
    end else begin
      second_pin_out <= second_out_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      second_pin_oe <= 8'h00;
    end else begin
      second_pin_oe <= second_oe_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      keypad_wake_input <= 4'h0;
    end else begin
      keypad_wake_input <= s2_r[7:4] & ctrl_r.keypad_en;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_in <= 1'b1;
    end else begin
      sda_in <= s2_r[7] | ~ctrl_r.two_wire_en;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_in <= 1'b1;
    end else begin
      scl_in <= s2_r[6] | ~ctrl_r.two_wire_en;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_two_ext_clock <= 1'b0;
    end else begin
      timer_two_ext_clock <= s2_r[5] & (ctrl_r.t2_ps == `PS_EXT_CLOCK);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_one_ext_clock <= 1'b0;
    end else begin
      timer_one_ext_clock <= s2_r[4] & (ctrl_r.t1_ps == `PS_EXT_CLOCK);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      spi_in <= 4'h0;
    end else begin
      spi_in <= s2_r[3:0] & {4{ctrl_r.spi_en}};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      calibration_in <= 1'b0;
    end else begin
      calibration_in <= s2_r[0] & ctrl_r.cal_en;
    end
  end

  always_comb begin
    mapped = 1'b1;
    rd_nxt = 32'h00000000;
    case (paddr)
      `FIRST_DATA_OFS: rd_nxt[7:0] = (first_data_r & first_dir_r) | (s1_r & ~first_dir_r);
      `SECOND_DATA_OFS: rd_nxt[7:0] = (second_data_r & second_dir_r) | (s2_r & ~second_dir_r);
      `FIRST_DIR_OFS: rd_nxt[7:0] = first_dir_r;
      `SECOND_DIR_OFS: rd_nxt[7:0] = second_dir_r;
      `FIRST_HIGH_DRIVE_OFS: rd_nxt[7:0] = high_drive_r;
      `PERIPH_CTRL_OFS: rd_nxt[14:0] = ctrl_r;
      `PIN_STATUS_OFS: rd_nxt[15:0] = {s2_r, s1_r};
      default: mapped = 1'b0;
    endcase
  end

  // One wait state: answer in the access phase's second cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= (psel && penable && !pready && !pwrite) ? rd_nxt : 32'h00000000;
    end
  end

endmodule

/* core/port_cd_regs.svh */
/*
  Register offsets, field positions, reset values and sync depth for the port C/D block.
  Assumes an APB slave with 32-bit data and one aligned word per register.
*/
`ifndef PORT_CD_REGS_SVH
`define PORT_CD_REGS_SVH
// Printed offsets are word indices; the byte address is four times the index.
`define FIRST_DATA_IDX 10'h002
`define SECOND_DATA_IDX 10'h003
`define FIRST_DATA_OFS {`FIRST_DATA_IDX, 2'b00}
`define SECOND_DATA_OFS {`SECOND_DATA_IDX, 2'b00}
`define FIRST_DIR_OFS 12'h010
`define SECOND_DIR_OFS 12'h014
`define FIRST_HIGH_DRIVE_OFS 12'h018
`define PERIPH_CTRL_OFS 12'h01c
`define PIN_STATUS_OFS 12'h020
`define DIR_RESET 8'h00
`define HIGH_DRIVE_RESET 8'h00
`define PERIPH_CTRL_RESET 32'h00000000
`define CTRL_KEYPAD_LSB 0
`define CTRL_TWO_WIRE_BIT 4
`define CTRL_SPI_BIT 5
`define CTRL_CAL_BIT 6
`define CTRL_UPPER_FP_BIT 7
`define CTRL_LOWER_FP_BIT 8
`define CTRL_T1_PS_LSB 9
`define CTRL_T2_PS_LSB 12
`define PS_EXT_CLOCK 3'h7
`define SYNC_STAGES 3
`endif

/* core/port_cd_pkg.sv */
/*
  Types shared by the port C/D block.
  Assumes the register header is included alongside.
*/
package port_cd_pkg;
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } pin_drive_t;

  typedef struct packed {
    logic [2:0] t2_ps;
    logic [2:0] t1_ps;
    logic lower_fp;
    logic upper_fp;
    logic cal_en;
    logic spi_en;
    logic two_wire_en;
    logic [3:0] keypad_en;
  } periph_ctrl_t;
endpackage

/* dv/port_cd_gpio_props.sv */
/* Assertions on the port block outputs.
   Assumes binding into the top module. */
`timescale 1ns/10ps
module port_cd_gpio_props (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic psel, // Select
  input wire logic pwrite, // Write
  input wire logic [7:0] first_pin_oe, // Enables
  input wire logic [7:0] first_high_drive, // Sink
  input wire logic [7:0] second_pin_in, // Pins
  input wire logic [3:0] keypad_wake_input, // Keypad
  input wire logic timer_two_ext_clock, // Timer
  input wire logic timer_one_ext_clock, // Timer
  input wire logic calibration_in // Calibration
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_dir_rst;
    $rose(rst_n) |-> first_pin_oe == 8'h00;
  endproperty
  a_dir_rst: assert property (p_dir_rst) else $error("enable after reset");
  property p_hd_rst;
    $rose(rst_n) |-> first_high_drive == 8'h00;
  endproperty
  a_hd_rst: assert property (p_hd_rst) else $error("sink after reset");
  property p_hd_out;
    first_high_drive != 8'h00 |-> (first_high_drive & ~first_pin_oe) == 8'h00;
  endproperty
  a_hd_out: assert property (p_hd_out) else $error("sink on input");
  property p_oe_cause;
    $changed(first_pin_oe) |-> $past(psel && pwrite) || $past(psel && pwrite, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("enable moved alone");
  property p_keypad;
    !second_pin_in[7] [*8] |=> !keypad_wake_input[3];
  endproperty
  a_keypad: assert property (p_keypad) else $error("keypad level");
  property p_t2;
    !second_pin_in[5] [*8] |=> !timer_two_ext_clock;
  endproperty
  a_t2: assert property (p_t2) else $error("timer two level");
  property p_t1;
    !second_pin_in[4] [*8] |=> !timer_one_ext_clock;
  endproperty
  a_t1: assert property (p_t1) else $error("timer one level");
  property p_cal;
    !second_pin_in[0] [*8] |=> !calibration_in;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration level");
endmodule

/* dv/port_cd_pins.sv */
/* Pad model: a pad shows the block's drive when enabled, else the outside level.
   Assumes the bench supplies the outside levels. */
`timescale 1ns/10ps
module port_cd_pins (
  input wire logic [7:0] first_pin_out, // Drive
  input wire logic [7:0] first_pin_oe, // Enable
  input wire logic [7:0] second_pin_out, // Drive
  input wire logic [7:0] second_pin_oe, // Enable
  input wire logic [7:0] ext1, // Outside
  input wire logic [7:0] ext2, // Outside
  output logic [7:0] first_pin_in, // Pad
  output logic [7:0] second_pin_in // Pad
);
  assign first_pin_in = (first_pin_out & first_pin_oe) | (ext1 & ~first_pin_oe);
  assign second_pin_in = (second_pin_out & second_pin_oe) | (ext2 & ~second_pin_oe);
endmodule

/* dv/test_port_c_d_gpio_logic.sv */
/* Self-checking bench for the port block.
   Assumes the pad model and the bound checker. */
`timescale 1ns/10ps
`include "port_cd_regs.svh"
module test_port_c_d_gpio_logic
  import port_cd_pkg::*;
;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic sda_drive_low = 0, scl_drive_low = 0, calibration_out = 0, sda_in, scl_in;
  logic timer_two_ext_clock, timer_one_ext_clock, calibration_in;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, r;
  logic [7:0] first_pin_in, first_pin_out, first_pin_oe, first_high_drive, frontplane_sel;
  logic [7:0] second_pin_in, second_pin_out, second_pin_oe, dir, lat, hd;
  logic [7:0] frontplane_out = 0, ext1 = 0, ext2 = 0;
  logic [3:0] keypad_wake_input, spi_in;
  pin_drive_t spi_drive = '0;
  int n_errors = 0, cmp_count = 0, seed = 32'h4c1b6933;
  always #50 clk = ~clk;
  port_cd_gpio u_port_cd_gpio (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .first_pin_in, .first_pin_out, .first_pin_oe,
    .first_high_drive, .frontplane_out, .frontplane_sel, .second_pin_in, .second_pin_out,
    .second_pin_oe, .keypad_wake_input, .sda_drive_low, .scl_drive_low, .sda_in, .scl_in,
    .timer_two_ext_clock, .timer_one_ext_clock, .spi_drive, .spi_in, .calibration_out,
    .calibration_in);
  port_cd_pins u_port_cd_pins (.first_pin_out, .first_pin_oe, .second_pin_out,
    .second_pin_oe, .ext1, .ext2, .first_pin_in, .second_pin_in);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] pin_rd(input logic [7:0] d, input logic [7:0] l,
    input logic [7:0] x);
    return (l & d) | (x & ~d);
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(0, `FIRST_DIR_OFS, 0);
    chk(q, 0);
    apb(0, 12'h0fc, 0);
    chk(e, 1);
    chk(q, 0);
    repeat (12) begin
      r = $random(seed);
      {dir, lat, hd} = r[23:0];
      ext1 <= r[31:24];
      r = $random(seed);
      {frontplane_out, spi_drive, ext2} <= r;
      {sda_drive_low, scl_drive_low, calibration_out} <= r[2:0];
      apb(1, `FIRST_DATA_OFS, lat);
      apb(1, `FIRST_DIR_OFS, dir);
      apb(1, `FIRST_HIGH_DRIVE_OFS, hd);
      apb(1, `SECOND_DATA_OFS, hd);
      apb(1, `SECOND_DIR_OFS, dir);
      repeat (8) @(posedge clk);
      apb(0, `FIRST_DATA_OFS, 0);
      chk(q, pin_rd(dir, lat, ext1));
      apb(0, `SECOND_DATA_OFS, 0);
      chk(q, pin_rd(dir, hd, ext2));
      apb(0, `PIN_STATUS_OFS, 0);
      chk(q, {pin_rd(dir, hd, ext2), pin_rd(dir, lat, ext1)});
      chk({first_pin_oe, first_pin_out & dir}, {dir, lat & dir});
      chk(first_high_drive, hd & dir);
      chk({second_pin_oe, second_pin_out & dir}, {dir, hd & dir});
    end
    apb(1, `FIRST_DIR_OFS, 0);
    apb(1, `SECOND_DIR_OFS, 32'hff);
    apb(1, `PERIPH_CTRL_OFS, 32'h0f);
    repeat (8) @(posedge clk);
    chk({keypad_wake_input, second_pin_oe[7:4]}, {ext2[7:4], 4'h0});
    apb(1, `PERIPH_CTRL_OFS, 32'h7e00);
    repeat (8) @(posedge clk);
    chk({timer_two_ext_clock, timer_one_ext_clock, second_pin_oe[5:4]},
      {ext2[5:4], 2'b00});
    apb(0, `SECOND_DATA_OFS, 0);
    chk(q, hd);
    apb(1, `PERIPH_CTRL_OFS, 32'h40);
    repeat (8) @(posedge clk);
    chk({calibration_in, second_pin_out[3], second_pin_oe[3], second_pin_oe[0]},
      {ext2[0], calibration_out, 2'b10});
    apb(1, `PERIPH_CTRL_OFS, 32'h30);
    repeat (8) @(posedge clk);
    chk({second_pin_oe, second_pin_out[7:6], second_pin_out[3:0]}, {sda_drive_low,
      scl_drive_low, 2'b11, spi_drive.oe[3:0], 2'b00, spi_drive.dout[3:0]});
    chk({sda_in, scl_in, spi_in}, {ext2[7] & ~sda_drive_low, ext2[6] & ~scl_drive_low,
      (spi_drive.dout[3:0] & spi_drive.oe[3:0]) | (ext2[3:0] & ~spi_drive.oe[3:0])});
    apb(1, `PERIPH_CTRL_OFS, 32'h180);
    repeat (2) @(posedge clk);
    chk({frontplane_sel, first_pin_oe, first_pin_out},
      {8'hff, 8'hff, frontplane_out});
    apb(1, `FIRST_DATA_OFS, 32'h5a);
    apb(1, `SECOND_DATA_OFS, 32'ha5);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1, `FIRST_DIR_OFS, 32'hff);
    apb(1, `SECOND_DIR_OFS, 32'hff);
    apb(0, `FIRST_DATA_OFS, 0);
    chk(q, 32'h5a);
    apb(0, `SECOND_DATA_OFS, 0);
    chk(q, 32'ha5);
    print_verdict;
  end
endmodule
bind port_cd_gpio port_cd_gpio_props u_port_cd_gpio_props (.clk, .rst_n, .psel, .pwrite,
  .first_pin_oe, .first_high_drive, .second_pin_in, .keypad_wake_input,
  .timer_two_ext_clock, .timer_one_ext_clock, .calibration_in);
